/* File: rtl/scs_session_ctrl.v */
// secure channel teardown and bulk transfer session controller, AXI4-Lite slave
`timescale 1ns/1ps
`include "scs_map.vh"
// Notes on behaviour
// - bad teardown integrity code answers 98 62
// - unknown association still answers success
// - failed teardown answers error status
// - teardown P1 04, P2 80 send, A0 fetch
// - teardown payload wrapped in tag 73
// - one master object or connection objects only
// - master object is 88, 32, id, code
// - connection object is 8B, 32, id, code
// - abort makes bulk command carry no data
// - two P1 bits select four independent sessions
// - good non-final block answers 92 XX
// - status may flag pending data any session
// - good final block signals transaction ongoing
// - fetch with blocks left flags more pending
// - either side aborts, else session runs on
// - terminal abort drops data, keeps association
// - proactive flag lets terminal interleave, then resume
// - P1 b3 data flag, b6..b4 zero
// - P1 b2 aborts addressed session
// - P1 b1 resend, must be zero with b3
// - 92 SW2 bits: resend, proactive, session, more
// - 6A 84 always aborts the session
module scs_session_ctrl #(
	parameter ADDR_W = 8
) (
	// clock and reset
	input wire SYS_CLK,
	input wire NRST,
	// write address channel
	input wire [ADDR_W-1:0] S_AXI_AWADDR,
	input wire [2:0] S_AXI_AWPROT,
	input wire S_AXI_AWVALID,
	output wire S_AXI_AWREADY,
	// write data channel
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	output wire S_AXI_WREADY,
	// write response channel
	output wire [1:0] S_AXI_BRESP,
	output wire S_AXI_BVALID,
	input wire S_AXI_BREADY,
	// read address channel
	input wire [ADDR_W-1:0] S_AXI_ARADDR,
	input wire [2:0] S_AXI_ARPROT,
	input wire S_AXI_ARVALID,
	output wire S_AXI_ARREADY,
	// read data channel
	output wire [31:0] S_AXI_RDATA,
	output wire [1:0] S_AXI_RRESP,
	output wire S_AXI_RVALID,
	input wire S_AXI_RREADY
);
	// parser states
	localparam PS_WTAG = 3'd0;
	localparam PS_WLEN = 3'd1;
	localparam PS_WLEN2 = 3'd2;
	localparam PS_OTAG = 3'd3;
	localparam PS_OLEN = 3'd4;
	localparam PS_BODY = 3'd5;
	localparam PS_BAD = 3'd6;
	// object kinds seen so far
	localparam K_NONE = 2'd0;
	localparam K_MASTER = 2'd1;
	localparam K_CONN = 2'd2;
	localparam [1:0] RESP_OKAY = 2'b00;
	localparam [1:0] RESP_SLVERR = 2'b10;

	// merge written bytes into an old word under byte strobes
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i])
					merge[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
	endfunction

	// pick the session whose outbound data is flagged: current first, else lowest other
	function [2:0] pend_pick;
		input [15:0] blk;
		input [1:0] cur;
		input [3:0] cur_left;
		integer i;
		begin
			pend_pick = (cur_left != 4'h0) ? {1'b1, cur} : 3'b000;
			for (i = 3; i >= 0; i = i - 1) begin
				if (cur_left == 4'h0 && i[1:0] != cur && blk[i*4 +: 4] != 4'h0)
					pend_pick = {1'b1, i[1:0]};
			end
		end
	endfunction

	// ongoing status word: SW2 = 000, resend, proactive, session, more
	function [15:0] sw_ongoing;
		input resend;
		input pro;
		input [1:0] sess;
		input more;
		begin
			sw_ongoing = {`SCS_SW1_ONGOING, 3'b000, resend, pro, sess, more};
		end
	endfunction

	// bus slave state
	reg aw_full_q;
	reg [ADDR_W-1:0] aw_addr_q;
	reg w_full_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg bvalid_q;
	reg [1:0] bresp_q;
	reg rvalid_q;
	reg [31:0] rdata_q;
	reg [1:0] rresp_q;
	// block state
	reg [4:0] verdict_q; // crypto and store verdicts from software
	reg [15:0] outblk_q; // outbound blocks left, 4 bits per session
	reg [3:0] active_q; // session running flags
	reg [15:0] sw_q; // latest status word of any command
	reg [15:0] last_sw_q [0:3]; // latest response per session
	// teardown payload parser
	reg [2:0] ps_q;
	reg [7:0] wlen_q; // wrapper value length
	reg [7:0] seen_q; // value bytes consumed
	reg [4:0] body_q; // byte index inside an object body
	reg [1:0] kind_q;

	// handshakes: one write and one read in flight at a time
	assign S_AXI_AWREADY = !aw_full_q && !bvalid_q;
	assign S_AXI_WREADY = !w_full_q && !bvalid_q;
	assign S_AXI_BVALID = bvalid_q;
	assign S_AXI_BRESP = bresp_q;
	assign S_AXI_ARREADY = !rvalid_q;
	assign S_AXI_RVALID = rvalid_q;
	assign S_AXI_RDATA = rdata_q;
	assign S_AXI_RRESP = rresp_q;

	// write commit once address and data are both held
	wire wr_go = aw_full_q && w_full_q && !bvalid_q;
	wire [7:0] wr_off = aw_addr_q[7:0] & 8'hfc; // needs ADDR_W of at least 8
	wire wr_cmd = wr_go && wr_off == `SCS_OFF_CMD && w_strb_q[2:0] == 3'b111;
	wire wr_tdb = wr_go && wr_off == `SCS_OFF_TDBYTE && w_strb_q[0];
	wire wr_map = wr_off == `SCS_OFF_CMD || wr_off == `SCS_OFF_TDBYTE ||
		wr_off == `SCS_OFF_VERDICT || wr_off == `SCS_OFF_OUTBLK;
	wire [31:0] mrg = merge(wr_off[2] ? {16'h0, outblk_q} : {27'h0, verdict_q}, w_data_q, w_strb_q);

	// command fields
	wire [7:0] p1 = w_data_q[`SCS_CMD_P1_LSB +: 8];
	wire [7:0] p2 = w_data_q[`SCS_CMD_P2_LSB +: 8];
	wire tear = w_data_q[`SCS_CMD_TEAR_BIT];
	wire [1:0] sess = p1[7:6];
	wire [3:0] left = outblk_q[sess*4 +: 4];
	wire [2:0] pick = pend_pick(outblk_q, sess, left);
	wire [2:0] pick_oth = pend_pick(outblk_q, sess, 4'h0); // other sessions only
	wire pro = verdict_q[`SCS_VER_PROACTIVE];
	wire [7:0] tb = w_data_q[7:0];

	// command decode results
	reg [15:0] ex_sw;
	reg ex_store; // remember as this session's latest response
	reg ex_act_set;
	reg ex_act_clr;
	reg ex_dec; // one outbound block delivered
	reg ex_drop; // discard outbound data of the session
	reg ex_prst; // restart the teardown parser

	// decode one executed command into its status word and side effects
	always @* begin
		ex_sw = `SCS_SW_OK;
		ex_store = 1'b0;
		ex_act_set = 1'b0;
		ex_act_clr = 1'b0;
		ex_dec = 1'b0;
		ex_drop = 1'b0;
		ex_prst = 1'b0;
		if (tear) begin
			// teardown of associations
			ex_prst = 1'b1;
			if (p1 != `SCS_P1_TEARDOWN) begin
				ex_sw = `SCS_SW_BAD_P1P2;
			end else if (p2 == `SCS_P2_RSP_DATA) begin
				ex_sw = `SCS_SW_OK; // no response data, nothing to fetch
			end else if (p2 != `SCS_P2_CMD_DATA) begin
				ex_sw = `SCS_SW_BAD_P1P2;
			end else if (ps_q != PS_OTAG || kind_q == K_NONE || seen_q != wlen_q) begin
				ex_sw = `SCS_SW_BAD_DATA; // truncated or malformed payload
			end else if (!verdict_q[`SCS_VER_MAC_OK]) begin
				ex_sw = `SCS_SW_BAD_MAC;
			end else if (verdict_q[`SCS_VER_CLOSE_FAIL]) begin
				ex_sw = `SCS_SW_CLOSE_FAIL;
			end else begin
				ex_sw = `SCS_SW_OK; // found or not, the answer is success
			end
		end else if (p1[5:3] != 3'b000 || (p1[2] && p1[0])) begin
			// reserved bits or resend with data
			ex_sw = `SCS_SW_BAD_P1P2;
		end else if (p1[1]) begin
			// terminal abort: no data either way, association untouched
			ex_act_clr = 1'b1;
			ex_drop = 1'b1;
			ex_sw = `SCS_SW_OK;
		end else if (p1[0]) begin
			// resend exactly what this session saw last
			ex_sw = last_sw_q[sess];
		end else if (verdict_q[`SCS_VER_NO_MEM]) begin
			// card side abort on lack of memory
			ex_sw = `SCS_SW_NO_MEM;
			ex_act_clr = 1'b1;
			ex_drop = 1'b1;
			ex_store = 1'b1;
		end else if (!p1[2] && p2 != 8'h00) begin
			// inbound blocks announced but no data carried
			ex_sw = `SCS_SW_WRONG_LEN;
		end else if (p1[2]) begin
			// inbound block; p2 zero marks the final one
			ex_act_set = 1'b1;
			ex_store = 1'b1;
			ex_sw = sw_ongoing(1'b0, pro, pick[2] ? pick[1:0] : sess, pick[2]);
		end else begin
			// outbound fetch; more flagged while blocks stay behind
			ex_store = 1'b1;
			ex_dec = left != 4'h0;
			ex_act_set = left > 4'h1;
			ex_act_clr = left <= 4'h1; // last block completes the session
			if (left > 4'h1)
				ex_sw = sw_ongoing(1'b0, pro, sess, 1'b1);
			else
				ex_sw = sw_ongoing(1'b0, pro, pick_oth[2] ? pick_oth[1:0] : sess,
					pick_oth[2]);
		end
	end

	// axi write channels: accept address and data in either order
	always @(posedge SYS_CLK) begin
		if (!NRST) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= {ADDR_W{1'b0}};
			w_full_q <= 1'b0;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_full_q <= 1'b1;
				w_data_q <= S_AXI_WDATA;
				w_strb_q <= S_AXI_WSTRB;
			end
			// response follows commit by one cycle
			if (wr_go) begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_map ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && S_AXI_BREADY) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// axi read channel: data one cycle after the address
	always @(posedge SYS_CLK) begin
		if (!NRST) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			rvalid_q <= 1'b1;
			rresp_q <= RESP_OKAY;
			case (S_AXI_ARADDR[7:0] & 8'hfc)
				`SCS_OFF_VERDICT: rdata_q <= {27'h0, verdict_q};
				`SCS_OFF_OUTBLK: rdata_q <= {16'h0000, outblk_q};
				`SCS_OFF_STATUS: rdata_q <= {9'h0, ps_q, active_q, sw_q};
				`SCS_OFF_LASTSW: rdata_q <= {last_sw_q[1], last_sw_q[0]};
				`SCS_OFF_CMD: rdata_q <= {last_sw_q[3], last_sw_q[2]};
				`SCS_OFF_TDBYTE: rdata_q <= {8'h00, seen_q, wlen_q, 3'b000, body_q};
				default: begin
					// unmapped word reads zero with an error answer
					rdata_q <= 32'h00000000;
					rresp_q <= RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && S_AXI_RREADY) begin
			rvalid_q <= 1'b0;
		end
	end

	// session bookkeeping and software registers
	always @(posedge SYS_CLK) begin
		if (!NRST) begin
			verdict_q <= `SCS_VER_RST;
			outblk_q <= `SCS_OUTBLK_RST;
			active_q <= 4'h0;
			sw_q <= `SCS_SW_RST;
			last_sw_q[0] <= `SCS_SW_RST;
			last_sw_q[1] <= `SCS_SW_RST;
			last_sw_q[2] <= `SCS_SW_RST;
			last_sw_q[3] <= `SCS_SW_RST;
		end else if (wr_go) begin
			if (wr_off == `SCS_OFF_VERDICT)
				verdict_q <= mrg[4:0];
			if (wr_off == `SCS_OFF_OUTBLK)
				outblk_q <= mrg[15:0];
			if (wr_cmd) begin
				// commands execute only one at a time, so no software write collides
				sw_q <= ex_sw;
				if (ex_store && !tear)
					last_sw_q[sess] <= ex_sw;
				if (ex_act_set && !tear)
					active_q[sess] <= 1'b1;
				if (ex_act_clr && !tear)
					active_q[sess] <= 1'b0;
				if (ex_drop && !tear)
					outblk_q[sess*4 +: 4] <= 4'h0;
				if (ex_dec && !tear)
					outblk_q[sess*4 +: 4] <= left - 4'h1;
			end
		end
	end

	// teardown payload parser, fed one byte per write
	always @(posedge SYS_CLK) begin
		if (!NRST) begin
			ps_q <= PS_WTAG;
			wlen_q <= 8'h00;
			seen_q <= 8'h00;
			body_q <= 5'h00;
			kind_q <= K_NONE;
		end else if (wr_cmd && ex_prst) begin
			// each teardown command starts a fresh payload
			ps_q <= PS_WTAG;
			seen_q <= 8'h00;
			kind_q <= K_NONE;
		end else if (wr_tdb) begin
			if (ps_q >= PS_OTAG && ps_q <= PS_BODY)
				seen_q <= seen_q + 8'h01;
			case (ps_q)
				PS_WTAG: begin
					ps_q <= (tb == `SCS_TAG_WRAP) ? PS_WLEN : PS_BAD;
				end
				PS_WLEN: begin
					wlen_q <= tb;
					ps_q <= (tb == `SCS_LEN_EXT) ? PS_WLEN2 : (tb[7] ? PS_BAD : PS_OTAG);
				end
				PS_WLEN2: begin
					wlen_q <= tb;
					ps_q <= tb[7] ? PS_OTAG : PS_BAD;
				end
				PS_OTAG: begin
					// a master object stands alone; connection objects may repeat
					if (tb == `SCS_TAG_MASTER && kind_q == K_NONE) begin
						kind_q <= K_MASTER;
						ps_q <= PS_OLEN;
					end else if (tb == `SCS_TAG_CONN && kind_q != K_MASTER) begin
						kind_q <= K_CONN;
						ps_q <= PS_OLEN;
					end else begin
						ps_q <= PS_BAD;
					end
				end
				PS_OLEN: begin
					body_q <= 5'h00;
					ps_q <= (tb == `SCS_OBJ_LEN) ? PS_BODY : PS_BAD;
				end
				PS_BODY: begin
					// 16 id bytes then 16 code bytes
					body_q <= body_q + 5'h01;
					if (body_q == `SCS_BODY_LAST)
						ps_q <= PS_OTAG;
				end
				PS_BAD: begin
					ps_q <= PS_BAD;
				end
				default: begin
					ps_q <= PS_BAD;
				end
			endcase
		end
	end
endmodule

/* File: rtl/scs_map.vh */
// register offsets, field positions, codes and reset values of the session controller
`ifndef SCS_MAP_VH
`define SCS_MAP_VH
// register byte offsets
`define SCS_OFF_CMD 8'h00
`define SCS_OFF_TDBYTE 8'h04
`define SCS_OFF_VERDICT 8'h08
`define SCS_OFF_OUTBLK 8'h0c
`define SCS_OFF_STATUS 8'h10
`define SCS_OFF_LASTSW 8'h14
// command register fields
`define SCS_CMD_P1_LSB 0
`define SCS_CMD_P2_LSB 8
`define SCS_CMD_TEAR_BIT 16
// verdict register fields
`define SCS_VER_MAC_OK 0
`define SCS_VER_FOUND 1
`define SCS_VER_CLOSE_FAIL 2
`define SCS_VER_NO_MEM 3
`define SCS_VER_PROACTIVE 4
`define SCS_VER_RST 5'h00
`define SCS_OUTBLK_RST 16'h0000
// P1 / P2 codes
`define SCS_P1_TEARDOWN 8'h04
`define SCS_P2_CMD_DATA 8'h80
`define SCS_P2_RSP_DATA 8'ha0
// tags and lengths
`define SCS_TAG_WRAP 8'h73
`define SCS_TAG_MASTER 8'h88
`define SCS_TAG_CONN 8'h8b
`define SCS_OBJ_LEN 8'h20
`define SCS_LEN_EXT 8'h81
`define SCS_BODY_LAST 5'h1f
// status words
`define SCS_SW_OK 16'h9000
`define SCS_SW_BAD_MAC 16'h9862
`define SCS_SW_NO_MEM 16'h6a84
`define SCS_SW_BAD_P1P2 16'h6a86
`define SCS_SW_BAD_DATA 16'h6a80
`define SCS_SW_CLOSE_FAIL 16'h6f00
`define SCS_SW_WRONG_LEN 16'h6700
`define SCS_SW1_ONGOING 8'h92
`define SCS_SW_RST 16'h0000
`endif

/* File: test/scs_session_ctrl_chk.sv */
// bus port checker for the session controller
`timescale 1ns/1ps
module scs_chk #(
	parameter ADDR_W = 8
) (
	// clock and reset
	input wire SYS_CLK,
	input wire NRST,
	// write side
	input wire [ADDR_W-1:0] S_AXI_AWADDR,
	input wire S_AXI_AWVALID,
	input wire S_AXI_AWREADY,
	input wire S_AXI_WVALID,
	input wire S_AXI_WREADY,
	input wire [1:0] S_AXI_BRESP,
	input wire S_AXI_BVALID,
	input wire S_AXI_BREADY,
	// read side
	input wire [ADDR_W-1:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	input wire S_AXI_ARREADY,
	input wire [31:0] S_AXI_RDATA,
	input wire [1:0] S_AXI_RRESP,
	input wire S_AXI_RVALID,
	input wire S_AXI_RREADY
);
	// address of the read under way, needed to know what rdata means
	reg [ADDR_W-1:0] ra_q;
	// both write channels taken at one edge
	wire aw_go = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	wire ar_go = S_AXI_ARVALID && S_AXI_ARREADY;
	always @(posedge SYS_CLK) begin
		if (ar_go) ra_q <= S_AXI_ARADDR;
	end
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!NRST);
	a_wr_latency: assert property (aw_go |=> !S_AXI_BVALID ##1 S_AXI_BVALID)
		else $error("write answer not two edges after accept");
	a_wr_unmapped: assert property (aw_go && S_AXI_AWADDR[7:2] > 6'd5 |=> ##1 S_AXI_BRESP == 2'b10)
		else $error("unmapped write not refused");
	a_wr_block: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
		else $error("write accepted while answer pending");
	a_b_drop: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
		else $error("write answer held after handshake");
	a_rd_latency: assert property (ar_go |=> S_AXI_RVALID && !S_AXI_ARREADY)
		else $error("read answer not one edge after accept");
	a_rd_unmapped: assert property (ar_go && S_AXI_ARADDR[7:2] > 6'd5
		|=> S_AXI_RRESP == 2'b10 && S_AXI_RDATA == 32'h0)
		else $error("unmapped read not refused");
	a_rd_mapped: assert property (ar_go && S_AXI_ARADDR[7:2] <= 6'd5 |=> S_AXI_RRESP == 2'b00)
		else $error("mapped read refused");
	a_r_drop: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID && S_AXI_ARREADY)
		else $error("read answer held after handshake");
	a_sw2_spare: assert property (S_AXI_RVALID && ra_q[7:2] == 6'd4 &&
		S_AXI_RDATA[15:8] == 8'h92 |-> S_AXI_RDATA[7:5] == 3'h0)
		else $error("spare status bits set");
endmodule
bind scs_session_ctrl scs_chk #(.ADDR_W(ADDR_W)) chk (.SYS_CLK, .NRST, .S_AXI_AWADDR,
	.S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP,
	.S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
	.S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);

/* File: test/scs_host.sv */
// terminal side bus master that issues commands to the controller
`timescale 1ns/1ps
module scs_host (
	// clock
	input wire clk,
	// write channels
	output reg [7:0] awaddr,
	output reg awvalid,
	input wire awready,
	output reg [31:0] wdata,
	output reg [3:0] wstrb,
	output reg wvalid,
	input wire wready,
	input wire [1:0] bresp,
	input wire bvalid,
	output reg bready,
	// read channels
	output reg [7:0] araddr,
	output reg arvalid,
	input wire arready,
	input wire [31:0] rdata,
	input wire [1:0] rresp,
	input wire rvalid,
	output reg rready
);
	// answers are always welcome, so the ready lines never toggle
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, araddr, arvalid} <= 55'h0;
		{bready, rready} <= 2'b11;
	end
	// one write; released lines show the inverse so stale values cannot pass
	task wr(input [7:0] a, input [31:0] d, input [3:0] s, output [1:0] r);
		reg ad;
		reg wd;
		begin
			awaddr <= a;
			wdata <= d;
			wstrb <= s;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			ad = 1'b0;
			wd = 1'b0;
			while (!(ad && wd)) begin
				@(posedge clk);
				if (awvalid && awready) ad = 1'b1;
				if (wvalid && wready) wd = 1'b1;
				if (ad) {awvalid, awaddr} <= {1'b0, ~a};
				if (wd) {wvalid, wdata} <= {1'b0, ~d};
			end
			@(posedge clk);
			while (!bvalid) @(posedge clk);
			r = bresp;
		end
	endtask
	// one read
	task rd(input [7:0] a, output [31:0] d, output [1:0] r);
		begin
			araddr <= a;
			arvalid <= 1'b1;
			@(posedge clk);
			while (!arready) @(posedge clk);
			{arvalid, araddr} <= {1'b0, ~a};
			@(posedge clk);
			while (!rvalid) @(posedge clk);
			d = rdata;
			r = rresp;
		end
	endtask
endmodule

/* File: test/scs_session_ctrl_tb.sv */
// self-checking bench for the session controller
`timescale 1ns/1ps
`include "scs_map.vh"
module scs_session_ctrl_tb;
	reg SYS_CLK = 1'b0;
	reg NRST = 1'b0;
	wire [7:0] awaddr, araddr;
	wire [31:0] wdata, rdata;
	wire [3:0] wstrb;
	wire [1:0] bresp, rresp;
	wire awvalid, awready, wvalid, wready, bvalid, bready;
	wire arvalid, arready, rvalid, rready;
	integer n_fail = 0;
	integer n_checks = 0;
	integer cyc = 0;
	reg [31:0] st;
	reg [1:0] r;
	scs_host h (.clk(SYS_CLK), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	// protection inputs are ignored by the block, so they are tied
	scs_session_ctrl #(.ADDR_W(8)) dut (.SYS_CLK(SYS_CLK), .NRST(NRST),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready));
	always #25 SYS_CLK = ~SYS_CLK;
	// hang guard, well above the fewer than two thousand cycles the run needs
	always @(posedge SYS_CLK) begin
		cyc = cyc + 1;
		if (cyc == 30000) begin
			n_fail = n_fail + 1;
			summarize;
		end
	end
	task summarize;
		begin
			$display("checks %0d mismatches %0d", n_checks, n_fail);
			if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
			else $display("TESTS FAILED");
			$finish;
		end
	endtask
	task chk(input [31:0] g, input [31:0] e);
		begin
			n_checks = n_checks + 1;
			if (g !== e) begin
				$display("Error at %0t got %h expected %h", $time, g, e);
				n_fail = n_fail + 1;
			end
		end
	endtask
	task rd(input [7:0] a, input [31:0] e, input [1:0] er);
		begin
			h.rd(a, st, r);
			chk(st, e);
			chk({30'h0, r}, {30'h0, er});
		end
	endtask
	task wr(input [7:0] a, input [31:0] d, input [1:0] er);
		begin
			h.wr(a, d, 4'hf, r);
			chk({30'h0, r}, {30'h0, er});
		end
	endtask
	// one payload byte for the teardown parser
	task bw(input [7:0] b);
		h.wr(`SCS_OFF_TDBYTE, {24'h0, b}, 4'h1, r);
	endtask
	// wrapper, then objects with tags t1 and t2 at 34 byte spacing
	task td(input [7:0] wl, input [7:0] t1, input [7:0] t2, input [7:0] ol);
		integer i;
		begin
			bw(`SCS_TAG_WRAP);
			if (wl[7]) bw(`SCS_LEN_EXT);
			bw(wl);
			for (i = 0; i < wl; i = i + 1) begin
				if (i == 0) bw(t1);
				else if (i % 34 == 0) bw(t2);
				else if (i % 34 == 1) bw(ol);
				else bw(i[7:0]);
			end
		end
	endtask
	// issue a command and compare the status word it leaves
	task sw(input [7:0] p1, input [7:0] p2, input t, input [15:0] e);
		begin
			wr(`SCS_OFF_CMD, {15'h0, t, p2, p1}, 2'b00);
			h.rd(`SCS_OFF_STATUS, st, r);
			chk({16'h0, st[15:0]}, {16'h0, e});
		end
	endtask
	initial begin
		repeat (16) @(posedge SYS_CLK);
		NRST <= 1'b1;
		@(posedge SYS_CLK);
		rd(`SCS_OFF_VERDICT, 32'h0, 2'b00);
		rd(`SCS_OFF_STATUS, 32'h0, 2'b00);
		rd(8'h18, 32'h0, 2'b10);
		wr(8'h18, 32'h1, 2'b10);
		wr(`SCS_OFF_VERDICT, 32'h01, 2'b00);
		td(8'h22, 8'h88, 8'h88, 8'h20);
		sw(8'h04, 8'h80, 1'b1, 16'h9000);
		wr(`SCS_OFF_VERDICT, 32'h00, 2'b00);
		td(8'h22, 8'h88, 8'h88, 8'h20);
		sw(8'h04, 8'h80, 1'b1, 16'h9862);
		wr(`SCS_OFF_VERDICT, 32'h05, 2'b00);
		td(8'h22, 8'h88, 8'h88, 8'h20);
		sw(8'h04, 8'h80, 1'b1, 16'h6f00);
		wr(`SCS_OFF_VERDICT, 32'h01, 2'b00);
		td(8'h44, 8'h8b, 8'h8b, 8'h20);
		sw(8'h04, 8'h80, 1'b1, 16'h9000);
		td(8'h88, 8'h8b, 8'h8b, 8'h20);
		sw(8'h04, 8'h80, 1'b1, 16'h9000);
		td(8'h44, 8'h88, 8'h8b, 8'h20);
		sw(8'h04, 8'h80, 1'b1, 16'h6a80);
		td(8'h22, 8'h89, 8'h00, 8'h20);
		sw(8'h04, 8'h80, 1'b1, 16'h6a80);
		td(8'h22, 8'h88, 8'h00, 8'h1f);
		sw(8'h04, 8'h80, 1'b1, 16'h6a80);
		sw(8'h05, 8'h80, 1'b1, 16'h6a86);
		sw(8'h04, 8'ha0, 1'b1, 16'h9000);
		sw(8'h44, 8'h01, 1'b0, 16'h9202);
		sw(8'h44, 8'h00, 1'b0, 16'h9202);
		wr(`SCS_OFF_OUTBLK, 32'h0300, 2'b00);
		sw(8'h80, 8'h00, 1'b0, 16'h9205);
		rd(`SCS_OFF_OUTBLK, 32'h0200, 2'b00);
		sw(8'h80, 8'h00, 1'b0, 16'h9205);
		wr(`SCS_OFF_OUTBLK, 32'h2100, 2'b00);
		sw(8'h80, 8'h00, 1'b0, 16'h9207);
		rd(`SCS_OFF_OUTBLK, 32'h2000, 2'b00);
		sw(8'h81, 8'h00, 1'b0, 16'h9207);
		sw(8'h41, 8'h00, 1'b0, 16'h9202);
		rd(`SCS_OFF_LASTSW, 32'h9202_0000, 2'b00);
		rd(`SCS_OFF_CMD, 32'h0000_9207, 2'b00);
		sw(8'h08, 8'h00, 1'b0, 16'h6a86);
		sw(8'h05, 8'h00, 1'b0, 16'h6a86);
		sw(8'h00, 8'h01, 1'b0, 16'h6700);
		sw(8'h44, 8'h00, 1'b0, 16'h9207);
		sw(8'hc2, 8'h00, 1'b0, 16'h9000);
		rd(`SCS_OFF_OUTBLK, 32'h0000, 2'b00);
		sw(8'h44, 8'h00, 1'b0, 16'h9202);
		sw(8'h04, 8'h00, 1'b0, 16'h9200);
		wr(`SCS_OFF_VERDICT, 32'h09, 2'b00);
		sw(8'h04, 8'h00, 1'b0, 16'h6a84);
		chk({28'h0, st[19:16]}, 32'h2);
		wr(`SCS_OFF_VERDICT, 32'h11, 2'b00);
		sw(8'h44, 8'h00, 1'b0, 16'h920a);
		summarize;
	end
endmodule
